// [pkg/dpm_pkg.sv]
// Constants and types for the dual-port block memory
package dpm_pkg;
  localparam int ADDR_W   = 14;
  localparam int DATA_W   = 32;
  localparam int EXTRA_W  = 4;
  localparam int WORD_W   = 36;
  localparam int DEPTH    = 512;
  localparam int WIDX_W   = 9;
  localparam int OFF_W    = 5;
  localparam int AXI_AW   = 8;
  // Port width codes: total widths 1, 2, 4, 9, 18, 36
  localparam logic [2:0] W1  = 3'h0;
  localparam logic [2:0] W2  = 3'h1;
  localparam logic [2:0] W4  = 3'h2;
  localparam logic [2:0] W9  = 3'h3;
  localparam logic [2:0] W18 = 3'h4;
  localparam logic [2:0] W36 = 3'h5;
  localparam logic [5:0][31:0] DMASK = {32'hFFFFFFFF, 32'h0000FFFF,
    32'h000000FF, 32'h0000000F, 32'h00000003, 32'h00000001};
  localparam logic [5:0][3:0] EMASK = {4'hF, 4'h3, 4'h1, 4'h0, 4'h0, 4'h0};
  localparam logic [4:0] OFF0 = 5'h00;
  typedef enum logic [1:0] {
    DPM_NEW  = 2'h0,
    DPM_OLD  = 2'h1,
    DPM_HOLD = 2'h2
  } dpm_mode_t;
  // Register byte addresses
  localparam logic [7:0] REG_CFG_A  = 8'h00;
  localparam logic [7:0] REG_PRE_A  = 8'h04;
  localparam logic [7:0] REG_PREX_A = 8'h08;
  localparam logic [7:0] REG_CFG_B  = 8'h10;
  localparam logic [7:0] REG_PRE_B  = 8'h14;
  localparam logic [7:0] REG_PREX_B = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam int PORT_SEL_BIT = 4;
  // Configuration fields
  localparam int CFG_WID_LSB  = 0;
  localparam int CFG_MODE_LSB = 4;
  localparam int CFG_INV_LSB  = 8;
  localparam int INV_CLK      = 0;
  localparam int INV_WE       = 1;
  localparam int INV_EN       = 2;
  localparam int INV_PRE      = 3;
  localparam int ST_COLL      = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hw/dpm_block_memory.sv]
// Dual-port block memory with AXI4-Lite configuration registers
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module dpm_block_memory (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        port_a_clock,
  input  wire logic        port_a_active,
  input  wire logic        port_a_write_strobe,
  input  wire logic        port_a_output_preset,
  input  wire logic [13:0] port_a_addr,
  input  wire logic [31:0] port_a_write_word_in,
  input  wire logic [3:0]  port_a_extra_write_bits,
  output logic [31:0]      port_a_read_word,
  output logic [3:0]       port_a_extra_read_bits,
  input  wire logic        port_b_clock,
  input  wire logic        port_b_active,
  input  wire logic        port_b_write_strobe,
  input  wire logic        port_b_output_preset,
  input  wire logic [13:0] port_b_addr,
  input  wire logic [31:0] port_b_write_word_in,
  input  wire logic [3:0]  port_b_extra_write_bits,
  output logic [31:0]      port_b_read_word,
  output logic [3:0]       port_b_extra_read_bits
);

  typedef struct packed {
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
    logic                        aw_have;
    logic [7:0]                  awaddr;
    logic                        w_have;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic [1:0][2:0]             wid;
    dpm_pkg::dpm_mode_t [1:0]    mode;
    logic [1:0][3:0]             inv;
    logic [1:0][35:0]            pre;
    logic [1:0]                  clk_prev;
    logic [1:0][35:0]            latch;
    logic                        collide;
  } dpm_state_t;

  localparam dpm_state_t S_RST = '{
    wid:     {2{dpm_pkg::W36}},
    mode:    {2{dpm_pkg::DPM_NEW}},
    default: '0
  };

  dpm_state_t       s;
  dpm_state_t       n;
  logic [35:0]      mem [dpm_pkg::DEPTH];
  logic [1:0]       pclk;
  logic [1:0]       pen;
  logic [1:0]       pwe;
  logic [1:0]       ppre;
  logic [1:0][13:0] paddr;
  logic [1:0][35:0] pwin;
  logic [1:0]       act;
  logic [1:0]       edg;
  logic [1:0]       ena;
  logic [1:0]       ev;
  logic [1:0]       we_s;
  logic [1:0]       ps;
  logic [1:0][8:0]  widx;
  logic [1:0][4:0]  off;
  logic [1:0][35:0] rd;
  logic [1:0][35:0] pre_m;
  logic [1:0][35:0] win_m;
  logic [1:0][35:0] nw;
  logic [35:0]      base;
  logic [31:0]      m;
  logic             pi;
  logic             ri;

  assign pclk  = {port_b_clock, port_a_clock};
  assign pen   = {port_b_active, port_a_active};
  assign pwe   = {port_b_write_strobe, port_a_write_strobe};
  assign ppre  = {port_b_output_preset, port_a_output_preset};
  assign paddr = {port_b_addr, port_a_addr};
  assign pwin  = {port_b_extra_write_bits, port_b_write_word_in,
                  port_a_extra_write_bits, port_a_write_word_in};

  ////////////////////////////////////////////////////////////////////////////
  // Port geometry

  // Word index of a port address
  function automatic logic [8:0] f_word(input logic [2:0]  c,
                                        input logic [13:0] a);
    case (c)
      dpm_pkg::W1:  f_word = a[13:5];
      dpm_pkg::W2:  f_word = a[12:4];
      dpm_pkg::W4:  f_word = a[11:3];
      dpm_pkg::W9:  f_word = a[10:2];
      dpm_pkg::W18: f_word = a[9:1];
      default:      f_word = a[8:0];
    endcase
  endfunction

  // Data bit offset inside the word
  function automatic logic [4:0] f_off(input logic [2:0]  c,
                                       input logic [13:0] a);
    case (c)
      dpm_pkg::W1:  f_off = a[4:0];
      dpm_pkg::W2:  f_off = {a[3:0], 1'b0};
      dpm_pkg::W4:  f_off = {a[2:0], 2'b00};
      dpm_pkg::W9:  f_off = {a[1:0], 3'b000};
      dpm_pkg::W18: f_off = {a[0], 4'b0000};
      default:      f_off = dpm_pkg::OFF0;
    endcase
  endfunction

  // Extract a port-wide slice; extra bit k belongs to data byte k
  function automatic logic [35:0] f_get(input logic [2:0]  c,
                                        input logic [4:0]  o,
                                        input logic [35:0] w);
    logic [31:0] d;
    logic [3:0]  e;
    d = (w[31:0] >> o) & dpm_pkg::DMASK[c];
    e = (w[35:32] >> o[4:3]) & dpm_pkg::EMASK[c];
    f_get = {e, d};
  endfunction

  // Merge a port-wide slice into a stored word
  function automatic logic [35:0] f_put(input logic [2:0]  c,
                                        input logic [4:0]  o,
                                        input logic [35:0] w,
                                        input logic [35:0] v);
    logic [31:0] dm;
    logic [3:0]  em;
    dm = dpm_pkg::DMASK[c] << o;
    em = dpm_pkg::EMASK[c] << o[4:3];
    f_put = {(w[35:32] & ~em) | ((v[35:32] << o[4:3]) & em),
             (w[31:0] & ~dm) | ((v[31:0] << o) & dm)};
  endfunction

  function automatic logic [31:0] f_cfg(input logic [2:0]         w,
                                        input dpm_pkg::dpm_mode_t md,
                                        input logic [3:0]         iv);
    f_cfg = (32'(w) << dpm_pkg::CFG_WID_LSB) |
            (32'(md) << dpm_pkg::CFG_MODE_LSB) |
            (32'(iv) << dpm_pkg::CFG_INV_LSB);
  endfunction

  function automatic logic [31:0] f_strb(input logic [31:0] o,
                                         input logic [31:0] w,
                                         input logic [3:0]  st);
    for (int b = 0; b < 4; b++) begin
      f_strb[8*b +: 8] = st[b] ? w[8*b +: 8] : o[8*b +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n    = s;
    base = '0;
    m    = '0;
    pi   = s.awaddr[dpm_pkg::PORT_SEL_BIT];
    ri   = s_axi_araddr[dpm_pkg::PORT_SEL_BIT];
    if (s.awready && s_axi_awvalid) begin
      n.aw_have = 1'b1;
      n.awaddr  = s_axi_awaddr;
      pi        = s_axi_awaddr[dpm_pkg::PORT_SEL_BIT];
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;
    if (n.aw_have && n.w_have && !n.bvalid) begin
      n.bvalid  = 1'b1;
      n.bresp   = dpm_pkg::RESP_OKAY;
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      case (n.awaddr)
        dpm_pkg::REG_CFG_A, dpm_pkg::REG_CFG_B: begin
          m = f_strb(f_cfg(s.wid[pi], s.mode[pi], s.inv[pi]),
                     n.wdata, n.wstrb);
          n.wid[pi] = (m[dpm_pkg::CFG_WID_LSB +: 3] > dpm_pkg::W36) ?
                      dpm_pkg::W36 : m[dpm_pkg::CFG_WID_LSB +: 3];
          n.mode[pi] = dpm_pkg::dpm_mode_t'(m[dpm_pkg::CFG_MODE_LSB +: 2]);
          n.inv[pi]  = m[dpm_pkg::CFG_INV_LSB +: 4];
        end
        dpm_pkg::REG_PRE_A, dpm_pkg::REG_PRE_B: begin
          n.pre[pi][31:0] = f_strb(s.pre[pi][31:0], n.wdata, n.wstrb);
        end
        dpm_pkg::REG_PREX_A, dpm_pkg::REG_PREX_B: begin
          m = f_strb({28'h0000000, s.pre[pi][35:32]}, n.wdata, n.wstrb);
          n.pre[pi][35:32] = m[3:0];
        end
        dpm_pkg::REG_STATUS: begin
          if (n.wstrb[0] && n.wdata[dpm_pkg::ST_COLL]) n.collide = 1'b0;
        end
        default: n.bresp = dpm_pkg::RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready  = !n.w_have && !n.bvalid;

    if (s.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = dpm_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dpm_pkg::REG_CFG_A, dpm_pkg::REG_CFG_B:
          n.rdata = f_cfg(s.wid[ri], s.mode[ri], s.inv[ri]);
        dpm_pkg::REG_PRE_A, dpm_pkg::REG_PRE_B:
          n.rdata = s.pre[ri][31:0];
        dpm_pkg::REG_PREX_A, dpm_pkg::REG_PREX_B:
          n.rdata = {28'h0000000, s.pre[ri][35:32]};
        dpm_pkg::REG_STATUS:
          n.rdata = 32'(s.collide) << dpm_pkg::ST_COLL;
        default: begin
          n.rdata = '0;
          n.rresp = dpm_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.arready = !n.rvalid;

    for (int p = 0; p < 2; p++) begin
      act[p] = pclk[p] ^ s.inv[p][dpm_pkg::INV_CLK];
      edg[p] = act[p] & ~s.clk_prev[p];
      n.clk_prev[p] = act[p];
      ena[p]  = pen[p] ^ s.inv[p][dpm_pkg::INV_EN];
      ev[p]   = edg[p] & ena[p];
      we_s[p] = ev[p] & (pwe[p] ^ s.inv[p][dpm_pkg::INV_WE]);
      ps[p]   = ev[p] & (ppre[p] ^ s.inv[p][dpm_pkg::INV_PRE]);
      widx[p] = f_word(s.wid[p], paddr[p]);
      off[p]  = f_off(s.wid[p], paddr[p]);
      rd[p]    = f_get(s.wid[p], off[p], mem[widx[p]]);
      pre_m[p] = f_get(s.wid[p], dpm_pkg::OFF0, s.pre[p]);
      win_m[p] = f_get(s.wid[p], dpm_pkg::OFF0, pwin[p]);
      // Same-word writes from both ports merge A first, then B
      base  = (p == 1 && we_s[0] && widx[0] == widx[1]) ? nw[0] :
              mem[widx[p]];
      nw[p] = f_put(s.wid[p], off[p], base, pwin[p]);
      if (ps[p]) begin
        n.latch[p] = pre_m[p];
      end else if (ev[p] && !we_s[p]) begin
        n.latch[p] = rd[p];
      end else if (we_s[p]) begin
        case (s.mode[p])
          dpm_pkg::DPM_OLD:  n.latch[p] = rd[p];
          dpm_pkg::DPM_HOLD: n.latch[p] = s.latch[p];
          default:           n.latch[p] = win_m[p];
        endcase
      end
    end
    // Reader sees old contents; flagged only
    if (ev[0] && ev[1] && widx[0] == widx[1] && (we_s[0] != we_s[1])) begin
      n.collide = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and storage

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= S_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && reset_n) begin
      for (int p = 0; p < 2; p++) begin
        if (we_s[p]) mem[widx[p]] <= nw[p];
      end
    end
  end

  assign s_axi_awready          = s.awready;
  assign s_axi_wready           = s.wready;
  assign s_axi_bresp            = s.bresp;
  assign s_axi_bvalid           = s.bvalid;
  assign s_axi_arready          = s.arready;
  assign s_axi_rdata            = s.rdata;
  assign s_axi_rresp            = s.rresp;
  assign s_axi_rvalid           = s.rvalid;
  assign port_a_read_word       = s.latch[0][31:0];
  assign port_a_extra_read_bits = s.latch[0][35:32];
  assign port_b_read_word       = s.latch[1][31:0];
  assign port_b_extra_read_bits = s.latch[1][35:32];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  for (genvar g = 0; g < 2; g++) begin : g_chk
    sequence s_wr;
      ce && we_s[g] && !(we_s[1-g] && widx[0] == widx[1]);
    endsequence
    chk_write_store: assert property (@(posedge clk) disable iff (!reset_n)
      s_wr |=> f_get($past(s.wid[g]), $past(off[g]), mem[$past(widx[g])])
               == $past(win_m[g]))
      else $error("stored word differs from written word");
    chk_read_data: assert property (@(posedge clk) disable iff (!reset_n)
      ce && ev[g] && !we_s[g] && !ps[g] |=> s.latch[g] == $past(rd[g]))
      else $error("read latch differs from addressed contents");
    chk_new_data: assert property (@(posedge clk) disable iff (!reset_n)
      ce && we_s[g] && !ps[g] && s.mode[g] == dpm_pkg::DPM_NEW
      |=> s.latch[g] == $past(win_m[g]))
      else $error("new-data latch wrong");
    chk_old_data: assert property (@(posedge clk) disable iff (!reset_n)
      ce && we_s[g] && !ps[g] && s.mode[g] == dpm_pkg::DPM_OLD
      |=> s.latch[g] == $past(rd[g]))
      else $error("old-data latch wrong");
    chk_hold_out: assert property (@(posedge clk) disable iff (!reset_n)
      ce && we_s[g] && !ps[g] && s.mode[g] == dpm_pkg::DPM_HOLD
      |=> $stable(s.latch[g]))
      else $error("hold latch changed during write");
    chk_disabled_idle: assert property (@(posedge clk) disable iff (!reset_n)
      ce && edg[g] && !ena[g] ##1 !ev[g] |-> $stable(s.latch[g]))
      else $error("disabled port changed latch");
    chk_preset_out: assert property (@(posedge clk) disable iff (!reset_n)
      ce && ps[g] |=> s.latch[g] == $past(pre_m[g]))
      else $error("preset value not in latch");
    chk_no_edge: assert property (@(posedge clk) disable iff (!reset_n)
      !(ce && edg[g]) |=> $stable(s.latch[g]))
      else $error("latch changed without active edge");
  end

endmodule

// [tb/dpm_port_model.sv]
// User logic model driving one memory port of the block memory
`timescale 1ns/1ns
module dpm_port_model (
  input  wire logic        clk,
  input  wire logic [3:0]  inv,
  output logic             port_clock,
  output logic             active,
  output logic             write_strobe,
  output logic             output_preset,
  output logic [13:0]      addr,
  output logic [31:0]      wdata,
  output logic [3:0]       wextra,
  output logic             done
);
  initial begin
    port_clock = 1'b0;
    active = 1'b0;
    write_strobe = 1'b0;
    output_preset = 1'b0;
    addr = 14'h0000;
    wdata = 32'h00000000;
    wextra = 4'h0;
    done = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // One frame: clock low, clock high with request, hold, release
  task automatic op(input logic a, input logic w, input logic p,
                    input logic [13:0] ad, input logic [31:0] d,
                    input logic [3:0] x);
    @(posedge clk);
    port_clock <= inv[0];
    @(posedge clk);
    port_clock <= ~inv[0];
    active <= a ^ inv[2];
    write_strobe <= w ^ inv[1];
    output_preset <= p ^ inv[3];
    addr <= ad;
    wdata <= d;
    wextra <= x;
    @(posedge clk);
    @(posedge clk);
    port_clock <= inv[0];
    // Released lines show the inverse of their last value
    active <= ~active;
    write_strobe <= ~write_strobe;
    output_preset <= ~output_preset;
    addr <= ~addr;
    wdata <= ~wdata;
    wextra <= ~wextra;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
  // Park raw clock and enable levels before a polarity change
  task automatic park(input logic ck, input logic en);
    @(posedge clk);
    port_clock <= ck;
    active <= en;
    @(posedge clk);
  endtask
endmodule

// [tb/test_dpm_block_memory.sv]
// Self-checking testbench for the dual-port block memory
`timescale 1ns/1ns
module test_dpm_block_memory;
  logic        clk, reset_n, ce;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, port_a_read_word, port_b_read_word;
  logic [3:0]  s_axi_wstrb, port_a_extra_read_bits, port_b_extra_read_bits;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        a_ck, a_en, a_we, a_pr, a_dn, b_ck, b_en, b_we, b_pr, b_dn;
  logic [13:0] a_ad, b_ad, ad;
  logic [31:0] a_wd, b_wd, v;
  logic [3:0]  a_wx, b_wx, inv_a, inv_b;
  logic [35:0] mem [16];
  logic [35:0] lat [2];
  logic [35:0] prv [2];
  logic [35:0] qa[$], qb[$];
  logic [33:0] qr[$];
  logic [1:0]  qw[$];
  int          wc [2];
  int          md [2];
  int          seed, miscompares, cmp_count;
  dpm_block_memory i_dpm_block_memory (.clk, .reset_n, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_a_clock(a_ck), .port_a_active(a_en),
    .port_a_write_strobe(a_we), .port_a_output_preset(a_pr),
    .port_a_addr(a_ad), .port_a_write_word_in(a_wd),
    .port_a_extra_write_bits(a_wx), .port_a_read_word,
    .port_a_extra_read_bits, .port_b_clock(b_ck), .port_b_active(b_en),
    .port_b_write_strobe(b_we), .port_b_output_preset(b_pr),
    .port_b_addr(b_ad), .port_b_write_word_in(b_wd),
    .port_b_extra_write_bits(b_wx), .port_b_read_word,
    .port_b_extra_read_bits);
  dpm_port_model i_dpm_port_model_a (.clk, .inv(inv_a), .port_clock(a_ck),
    .active(a_en), .write_strobe(a_we), .output_preset(a_pr),
    .addr(a_ad), .wdata(a_wd), .wextra(a_wx), .done(a_dn));
  dpm_port_model i_dpm_port_model_b (.clk, .inv(inv_b), .port_clock(b_ck),
    .active(b_en), .write_strobe(b_we), .output_preset(b_pr),
    .addr(b_ad), .wdata(b_wd), .wextra(b_wx), .done(b_dn));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(string n, logic [35:0] s, logic [35:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Result monitor: oldest note against each answer
  always @(posedge clk) begin
    if (a_dn === 1'b1) check("port_a", {port_a_extra_read_bits,
      port_a_read_word}, qa.pop_front());
    if (b_dn === 1'b1) check("port_b", {port_b_extra_read_bits,
      port_b_read_word}, qb.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      check("bresp", 36'(s_axi_bresp), 36'(qw.pop_front()));
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      check("rdata", {2'h0, s_axi_rresp, s_axi_rdata},
            36'(qr.pop_front()));
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    qw.push_back(r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(logic [7:0] a, logic [33:0] e);
    qr.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic cfg(int p, int c, int m, logic [3:0] iv);
    logic [31:0] d;
    logic [7:0]  a;
    d = {20'h00000, iv, 2'h0, 2'(m), 1'b0, 3'(c)};
    a = p ? dpm_pkg::REG_CFG_B : dpm_pkg::REG_CFG_A;
    wc[p] = c;
    md[p] = m;
    axw(a, d, dpm_pkg::RESP_OKAY);
    axr(a, {dpm_pkg::RESP_OKAY, d});
  endtask
  // Lane placement of a port word within a 36-bit array word
  function automatic logic [35:0] sh(int c, logic [13:0] a,
                                     logic [35:0] x, bit up);
    int s;
    int ln;
    int ew;
    s = 5 - c;
    ew = (c < 3) ? 0 : 1 << (c - 3);
    ln = int'(a) & ((1 << s) - 1);
    if (up) return {x[35:32] << (ln * ew), x[31:0] << (ln * (1 << c))};
    return {x[35:32] >> (ln * ew), x[31:0] >> (ln * (1 << c))};
  endfunction
  function automatic logic [13:0] rad(int p);
    return 14'($random(seed)) & 14'((16 << (5 - wc[p])) - 1);
  endfunction
  task automatic mop(int p, logic act, logic we, logic pre, logic [13:0] a);
    logic [35:0] nv, m, old, e;
    int          c, w;
    c = wc[p];
    m = {dpm_pkg::EMASK[c], dpm_pkg::DMASK[c]};
    w = int'(a) >> (5 - c);
    nv[31:0] = $random(seed);
    nv[35:32] = 4'($random(seed));
    old = sh(c, a, mem[w], 1'b0) & m;
    e = lat[p];
    if (act) begin
      if (!we) e = old;
      else if (md[p] == 1) e = old;
      else if (md[p] == 0) e = nv & m;
      if (pre) e = prv[p] & m;
      if (we) mem[w] = (mem[w] & ~sh(c, a, m, 1'b1)) | sh(c, a, nv & m, 1'b1);
    end
    lat[p] = e;
    if (p == 1) begin
      qb.push_back(e);
      i_dpm_port_model_b.op(act, we, pre, a, nv[31:0], nv[35:32]);
    end else begin
      qa.push_back(e);
      i_dpm_port_model_a.op(act, we, pre, a, nv[31:0], nv[35:32]);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 85763;
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    ce = 1'b1;
    inv_a = 4'h0;
    inv_b = 4'h0;
    wc = '{5, 5};
    md = '{0, 0};
    lat = '{36'h000000000, 36'h000000000};
    prv = lat;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    axr(dpm_pkg::REG_CFG_A, {dpm_pkg::RESP_OKAY, 32'h00000005});
    axr(dpm_pkg::REG_PRE_B, {dpm_pkg::RESP_OKAY, 32'h00000000});
    axr(8'h3C, {dpm_pkg::RESP_SLVERR, 32'h00000000});
    axw(8'h3C, 32'hFFFFFFFF, dpm_pkg::RESP_SLVERR);
    axw(dpm_pkg::REG_CFG_B, 32'h00000007, dpm_pkg::RESP_OKAY);
    axr(dpm_pkg::REG_CFG_B, {dpm_pkg::RESP_OKAY, 32'h00000005});
    for (int i = 0; i < 16; i++) mop(0, 1'b1, 1'b1, 1'b0, 14'(i));
    for (int c = 0; c < 6; c++) begin
      for (int m = 0; m < 3; m++) begin
        cfg(1, c, m, 4'h0);
        repeat (2) begin
          ad = rad(1);
          mop(1, 1'b1, 1'b1, 1'b0, ad);
          mop(1, 1'b1, 1'b0, 1'b0, ad);
          mop(0, 1'b1, 1'b0, 1'b0, ad >> (5 - c));
        end
      end
    end
    cfg(1, 3, 1, 4'h0);
    for (int p = 0; p < 2; p++) begin
      ad = rad(p);
      v = $random(seed);
      prv[p] = {4'hA, v};
      axw(p ? dpm_pkg::REG_PRE_B : dpm_pkg::REG_PRE_A, v,
          dpm_pkg::RESP_OKAY);
      axw(p ? dpm_pkg::REG_PREX_B : dpm_pkg::REG_PREX_A, 32'h0000000A,
          dpm_pkg::RESP_OKAY);
      mop(p, 1'b0, 1'b1, 1'b0, ad);
      mop(p, 1'b1, 1'b1, 1'b1, ad);
      mop(p, 1'b1, 1'b0, 1'b1, ad);
      mop(p, 1'b1, 1'b0, 1'b0, ad);
    end
    i_dpm_port_model_a.park(1'b1, 1'b0);
    cfg(0, 5, 0, 4'hF);
    inv_a <= 4'hF;
    repeat (16) mop(0, 1'($random(seed)), 1'($random(seed)),
                    1'($random(seed)), rad(0));
    print_verdict();
  end
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule
